//--- pkg/acc_pkg.sv
// Constants and types for the control core.
// Assumes one 250 MHz clock; all times are converted to cycles of it.
// Function
// - Turbo comparison cycle from oscillator and divider
// - Eight channels configured independently
// - Kind, direction, driver decode channel role
// - Digital output drives output level bit
// - Window events may drive outputs
// - Pin level word shows every channel
// - One 3-bit averaging ratio for all
// - 16-bit result readable after completion
// - Host starts first; device starts the rest
// - Run time is samples times cycle
// - Bus-started run holds SCL low
// - Trigger start reports pollable done flag
// - Trigger result lands in latest registers
// - Autonomous mode walks masked channels in turn
// - Window compare uses upper 12 bits
// - Check byte logic only when enabled
// - Check byte is x^8+x^2+x+1 remainder
// - Check register starts from zero
// - Device recomputes and compares received check
// - Mismatch discards, flags error, blocks writes
// - Each sent byte followed by check byte
package acc_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int unsigned CLK_PERIOD_PS  = 4000;      // 250 MHz
   localparam int unsigned COMP_BASE_PS   = 312500;    // 0.3125 us, divider 0, fast oscillator
   localparam int unsigned SMP_BASE_PS    = 1000000;   // 1 us averaging cycle, divider 0, fast
   localparam int unsigned SLOW_OSC_RATIO = 32;        // Slow oscillator stretches cycle 32x
   localparam int          CNT_W          = 24;

   // ==========================================================
   // Check byte
   // ==========================================================
   localparam logic [7:0]  CRC_POLY = 8'h07;           // Low eight coefficients of 100000111
   localparam logic [7:0]  CRC_INIT = 8'h00;

   // ==========================================================
   // Averaging
   // ==========================================================
   localparam int          NUM_CH   = 8;
   localparam int          SMP_W    = 12;
   localparam int          RES_W    = 16;
   localparam int          ACC_W    = 19;              // 12 bits plus up to 128 samples
   localparam int          CMP_W    = 12;

   // Averaging sequencer states, one-hot
   typedef enum logic [3:0]
   {
      ACC_IDLE   = 4'b0001,
      ACC_SAMPLE = 4'b0010,
      ACC_WAIT   = 4'b0100,
      ACC_DONE   = 4'b1000
   } acc_state_t;

endpackage

//--- src/acc_core.sv
// Converter control core: turbo timing, pins, averaging, check bytes.
// Assumes a byte-level serial front end and a sampling converter.
`timescale 1ns/1ps
`default_nettype none

module acc_core
   import acc_pkg::*;
#(
   parameter int unsigned COMP_BASE_PS_P = COMP_BASE_PS,
   parameter int unsigned SMP_BASE_PS_P  = SMP_BASE_PS
)
(
   input  wire logic                clk,
   input  wire logic                nrst,
   // Timing setup
   input  wire logic                oscillator_select,
   input  wire logic [3:0]          clk_div,
   input  wire logic                turbo_mode,
   output logic                     comp_strobe,
   // Channel pins
   input  wire logic [NUM_CH-1:0]   pin_kind,
   input  wire logic [NUM_CH-1:0]   pin_dir,
   input  wire logic [NUM_CH-1:0]   output_driver_type,
   input  wire logic [NUM_CH-1:0]   output_level_word,
   input  wire logic [NUM_CH-1:0]   event_drive_en,
   input  wire logic [NUM_CH-1:0]   event_level,
   input  wire logic [NUM_CH-1:0]   window_event,
   input  wire logic [NUM_CH-1:0]   pad_in,
   output logic [NUM_CH-1:0]        pad_out,
   output logic [NUM_CH-1:0]        pad_oe,
   output logic [NUM_CH-1:0]        pin_level_word,
   // Averaging control
   input  wire logic [2:0]          averaging_ratio,
   input  wire logic                statistics_enable,
   input  wire logic                bus_conv_start,
   input  wire logic                conversion_trigger_bit,
   input  wire logic                autonomous_mode,
   input  wire logic [NUM_CH-1:0]   sequence_channel_mask,
   input  wire logic [2:0]          start_channel,
   input  wire logic                done_clear,
   output logic                     averaging_done_flag,
   output logic                     scl_hold_low,
   output logic                     run_busy,
   // Converter
   output logic                     sample_req,
   output logic [2:0]               sample_channel,
   input  wire logic                sample_valid,
   input  wire logic [SMP_W-1:0]    sample_data,
   // Results
   output logic [RES_W-1:0]         avg_result,
   output logic                     avg_valid,
   output logic [CMP_W-1:0]         cmp_value,
   input  wire logic [2:0]          read_channel,
   output logic [7:0]               latest_result_low,
   output logic [7:0]               latest_result_high,
   // Check byte, inbound
   input  wire logic                crc_en,
   input  wire logic                rx_valid,
   input  wire logic                rx_addr,
   input  wire logic [7:0]          rx_data,
   input  wire logic                error_clear,
   output logic                     inbound_check_error,
   output logic                     wr_valid,
   output logic [7:0]               wr_data,
   // Check byte, outbound
   input  wire logic                tx_load,
   input  wire logic [7:0]          tx_data,
   output logic                     tx_accept,
   output logic                     tx_valid,
   output logic [7:0]               tx_byte,
   input  wire logic                tx_ready
);

   // ==========================================================
   // Helpers
   // ==========================================================
   // Divider codes step 1, 1.5, 2, 3, 4, 6 ... times the base cycle
   function automatic logic [CNT_W-1:0] cycle_count(input logic [63:0] base_ps,
                                                   input logic [3:0]  div,
                                                   input logic        slow);
      logic [63:0] half_mult;
      logic [63:0] ps;
      half_mult = (div[0] ? 64'd3 : 64'd2) << div[3:1];
      ps        = (base_ps * half_mult) >> 1;
      if (slow)
         ps = ps * 64'(SLOW_OSC_RATIO);
      ps = ps / 64'(CLK_PERIOD_PS);          // Longest time, rounded down
      if (ps == 64'd0)
         ps = 64'd1;
      return CNT_W'(ps - 64'd1);
   endfunction

   // Bitwise division, register preset to zero
   function automatic logic [7:0] crc8(input logic [7:0] data);
      logic [7:0] r;
      r = CRC_INIT;
      for (int i = 7; i >= 0; i--)
      begin
         r = (r[7] ^ data[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   // Next masked channel after cur, wrapping; nearest one wins
   function automatic logic [2:0] next_chan(input logic [7:0] mask, input logic [2:0] cur);
      logic [2:0] n;
      logic [2:0] pick;
      pick = cur;
      for (int i = NUM_CH; i >= 1; i--)
      begin
         n = 3'(cur + 3'(i));
         if (mask[n])
            pick = n;
      end
      return pick;
   endfunction

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      acc_state_t                 state;
      logic [2:0]                 chan;
      logic [7:0]                 left;
      logic [CNT_W-1:0]           timer;
      logic [ACC_W-1:0]           acc;
      logic [2:0]                 ratio;
      logic                       stretch;
      logic                       by_trigger;
      logic                       done_flag;
      logic                       req;
      logic [RES_W-1:0]           avg;
      logic                       avg_valid;
      logic [NUM_CH*RES_W-1:0]    latest;
      logic [7:0]                 rd_low;
      logic [7:0]                 rd_high;
      logic [CNT_W-1:0]           comp_timer;
      logic                       comp_strobe;
      logic [NUM_CH-1:0]          pad_out;
      logic [NUM_CH-1:0]          pad_oe;
      logic [NUM_CH-1:0]          pin_level;
      logic                       rx_phase;
      logic [7:0]                 rx_hold;
      logic                       crc_err;
      logic                       wr_valid;
      logic [7:0]                 wr_data;
      logic                       tx_valid;
      logic                       tx_crc_pending;
      logic [7:0]                 tx_byte;
      logic [7:0]                 tx_crc;
   } acc_regs_t;

   acc_regs_t s_reg;
   acc_regs_t s_next;

   logic [CNT_W-1:0] comp_cycles;
   logic [CNT_W-1:0] smp_cycles;
   logic             start_any;
   logic             autonomous_go;
   logic [2:0]       auto_chan;
   logic [RES_W-1:0] result;
   logic             pin_drive;

   assign comp_cycles   = cycle_count(64'(COMP_BASE_PS_P), clk_div, oscillator_select);
   assign smp_cycles    = cycle_count(64'(SMP_BASE_PS_P), clk_div, oscillator_select);
   assign auto_chan     = next_chan(sequence_channel_mask, s_reg.chan);
   assign autonomous_go = autonomous_mode && (sequence_channel_mask != 8'h00);
   assign start_any     = bus_conv_start || (conversion_trigger_bit && statistics_enable) || autonomous_go;
   // Sum times 16 over sample count; widened first so no top bit is lost
   assign result        = RES_W'(({4'h0, s_reg.acc} << 4) >> s_reg.ratio);

   // ==========================================================
   // Next-state logic
   // ==========================================================
   always_comb
   begin
      s_next             = s_reg;
      s_next.req         = 1'b0;
      s_next.avg_valid   = 1'b0;
      s_next.comp_strobe = 1'b0;
      s_next.wr_valid    = 1'b0;
      pin_drive          = 1'b0;

      // Comparison tick in turbo mode
      if (!turbo_mode)
         s_next.comp_timer = comp_cycles;
      else if (s_reg.comp_timer == '0)
      begin
         s_next.comp_timer  = comp_cycles;
         s_next.comp_strobe = 1'b1;
      end
      else
         s_next.comp_timer = s_reg.comp_timer - 1'b1;

      // Averaging: one start, rest paced by timer
      if (s_reg.timer != '0)
         s_next.timer = s_reg.timer - 1'b1;
      case (s_reg.state)
         ACC_IDLE:
         begin
            if (start_any)
            begin
               s_next.state      = ACC_SAMPLE;
               s_next.ratio      = averaging_ratio;
               s_next.left       = 8'(8'd1 << averaging_ratio);
               s_next.acc        = '0;
               s_next.timer      = smp_cycles;
               s_next.req        = 1'b1;
               s_next.stretch    = bus_conv_start;
               s_next.by_trigger = !bus_conv_start && conversion_trigger_bit && statistics_enable;
               s_next.chan       = (bus_conv_start || s_next.by_trigger) ? start_channel : auto_chan;
            end
         end
         ACC_SAMPLE:
         begin
            if (sample_valid)
            begin
               s_next.acc   = s_reg.acc + ACC_W'(sample_data);
               s_next.left  = s_reg.left - 8'd1;
               s_next.state = ACC_WAIT;
            end
         end
         ACC_WAIT:
         begin
            // One full cycle per sample
            if (s_reg.timer == '0)
            begin
               if (s_reg.left == 8'd0)
                  s_next.state = ACC_DONE;
               else
               begin
                  s_next.state = ACC_SAMPLE;
                  s_next.timer = smp_cycles;
                  s_next.req   = 1'b1;
               end
            end
         end
         ACC_DONE:
         begin
            s_next.state     = ACC_IDLE;
            s_next.avg       = result;
            s_next.avg_valid = 1'b1;
            s_next.stretch   = 1'b0;
            s_next.latest[s_reg.chan*RES_W +: RES_W] = result;
            if (s_reg.by_trigger)
               s_next.done_flag = 1'b1;
         end
         default:
            s_next.state = ACC_IDLE;
      endcase
      // Set wins over a clear in the same cycle
      if (done_clear && !(s_reg.state == ACC_DONE && s_reg.by_trigger))
         s_next.done_flag = 1'b0;

      // Registered read port of the latest results
      s_next.rd_low  = s_next.latest[read_channel*RES_W +: 8];
      s_next.rd_high = s_next.latest[read_channel*RES_W + 8 +: 8];

      // Channel pins, each decoded on its own
      for (int i = 0; i < NUM_CH; i++)
      begin
         pin_drive = (event_drive_en[i] && window_event[i]) ? event_level[i]
                                                             : output_level_word[i];
         if (pin_kind[i] && pin_dir[i])
         begin
            // Open drain only pulls low; push-pull drives both levels
            s_next.pad_out[i] = output_driver_type[i] ? pin_drive : 1'b0;
            s_next.pad_oe[i]  = output_driver_type[i] ? 1'b1 : !pin_drive;
         end
         else
         begin
            s_next.pad_out[i] = 1'b0;
            s_next.pad_oe[i]  = 1'b0;
         end
      end
      s_next.pin_level = pad_in;

      // Inbound: data, then check byte if enabled
      if (rx_valid)
      begin
         if (rx_addr)
            s_next.rx_phase = 1'b0;
         else if (!crc_en)
         begin
            s_next.rx_phase = 1'b0;
            s_next.wr_valid = !s_reg.crc_err;
            s_next.wr_data  = rx_data;
         end
         else if (!s_reg.rx_phase)
         begin
            s_next.rx_phase = 1'b1;
            s_next.rx_hold  = rx_data;
         end
         else
         begin
            s_next.rx_phase = 1'b0;
            if (crc8(s_reg.rx_hold) == rx_data)
            begin
               s_next.wr_valid = !s_reg.crc_err;
               s_next.wr_data  = s_reg.rx_hold;
            end
            else
               s_next.crc_err = 1'b1;
         end
      end
      // Mismatch wins over a clear
      if (error_clear && !(rx_valid && !rx_addr && crc_en && s_reg.rx_phase
                           && crc8(s_reg.rx_hold) != rx_data))
         s_next.crc_err = 1'b0;

      // Outbound: each byte then its check byte
      if (s_reg.tx_valid && tx_ready)
      begin
         if (s_reg.tx_crc_pending)
         begin
            s_next.tx_byte        = s_reg.tx_crc;
            s_next.tx_crc_pending = 1'b0;
         end
         else
            s_next.tx_valid = 1'b0;
      end
      if (tx_load && !s_reg.tx_valid)
      begin
         s_next.tx_valid       = 1'b1;
         s_next.tx_byte        = tx_data;
         s_next.tx_crc         = crc8(tx_data);
         s_next.tx_crc_pending = crc_en;
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_reg       <= '0;
         s_reg.state <= ACC_IDLE;
      end
      else
         s_reg <= s_next;
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign comp_strobe         = s_reg.comp_strobe;
   assign pad_out             = s_reg.pad_out;
   assign pad_oe              = s_reg.pad_oe;
   assign pin_level_word      = s_reg.pin_level;
   assign averaging_done_flag = s_reg.done_flag;
   assign scl_hold_low        = s_reg.stretch;
   assign run_busy            = (s_reg.state != ACC_IDLE);
   assign sample_req          = s_reg.req;
   assign sample_channel      = s_reg.chan;
   assign avg_result          = s_reg.avg;
   assign avg_valid           = s_reg.avg_valid;
   assign cmp_value           = s_reg.avg[RES_W-1 -: CMP_W];
   assign latest_result_low   = s_reg.rd_low;
   assign latest_result_high  = s_reg.rd_high;
   assign inbound_check_error = s_reg.crc_err;
   assign wr_valid            = s_reg.wr_valid;
   assign wr_data             = s_reg.wr_data;
   assign tx_accept           = !s_reg.tx_valid;
   assign tx_valid            = s_reg.tx_valid;
   assign tx_byte             = s_reg.tx_byte;

endmodule

`default_nettype wire

//--- verif/acc_adc_model.sv
// Converter model: answers each request after adc_delay cycles.
// Assumes the core asks for one sample at a time.
`timescale 1ns/1ps
`default_nettype none
module acc_adc_model
   import acc_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             sample_req,
   input  wire logic [2:0]       sample_channel,
   input  wire logic [3:0]       adc_delay,
   output logic                  sample_valid,
   output logic [SMP_W-1:0]      sample_data
);
   // ==========
   // Answer
   // ==========
   // Data toggles outside the answer so a stale word never matches
   initial
   begin
      sample_valid = 1'b0;
      sample_data  = 12'h000;
      forever
      begin
         @(posedge clk);
         sample_data <= ~sample_data;
         if (sample_req)
         begin
            repeat (adc_delay) @(posedge clk);
            sample_valid <= 1'b1;
            sample_data  <= {sample_channel, 9'h0A5};
            @(posedge clk);
            sample_valid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

//--- verif/acc_core_assertions.sv
// Port-level checker for the core.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module acc_core_chk
   import acc_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic             turbo_mode,
   input  wire logic             comp_strobe,
   input  wire logic [7:0]       pin_kind,
   input  wire logic [7:0]       pin_dir,
   input  wire logic [7:0]       pad_in,
   input  wire logic [7:0]       pad_oe,
   input  wire logic [7:0]       pin_level_word,
   input  wire logic             bus_conv_start,
   input  wire logic             run_busy,
   input  wire logic             scl_hold_low,
   input  wire logic             sample_req,
   input  wire logic             averaging_done_flag,
   input  wire logic             avg_valid,
   input  wire logic [15:0]      avg_result,
   input  wire logic [11:0]      cmp_value,
   input  wire logic             crc_en,
   input  wire logic             rx_valid,
   input  wire logic             rx_addr,
   input  wire logic [7:0]       rx_data,
   input  wire logic             inbound_check_error,
   input  wire logic             wr_valid,
   input  wire logic [7:0]       wr_data,
   input  wire logic             tx_valid,
   input  wire logic             tx_ready,
   input  wire logic [7:0]       tx_byte
);
   // ==========
   // Helpers
   // ==========
   // Masks first edge after reset
   logic up_reg;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         up_reg <= 1'b0;
      else
         up_reg <= 1'b1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_bus_start;
      bus_conv_start && !run_busy;
   endsequence
   sequence s_plain_byte;
      rx_valid && !rx_addr && !crc_en && !inbound_check_error;
   endsequence
   // ==========
   // Assertions
   // ==========
   chk_turbo_only:
      assert property (comp_strobe |-> $past(turbo_mode)) else $error("strobe outside turbo mode");
   chk_analog_quiet:
      assert property (up_reg |-> (pad_oe & ~($past(pin_kind) & $past(pin_dir))) == 8'h00)
      else $error("pad driven on a non-output channel");
   chk_pin_level:
      assert property (up_reg |-> pin_level_word == $past(pad_in)) else $error("pin level word stale");
   chk_bus_stretch:
      assert property (s_bus_start |=> scl_hold_low && sample_req) else $error("bus run did not stretch");
   chk_stretch_end:
      assert property ($fell(scl_hold_low) |-> avg_valid) else $error("stretch ended before result");
   chk_done_cause:
      assert property ($rose(averaging_done_flag) |-> avg_valid) else $error("done flag without result");
   chk_cmp_upper:
      assert property (cmp_value == avg_result[15:4]) else $error("compare value not upper bits");
   chk_plain_write:
      assert property (s_plain_byte |=> wr_valid && wr_data == $past(rx_data))
      else $error("plain byte not written");
   chk_wr_blocked:
      assert property (wr_valid |-> !$past(inbound_check_error)) else $error("write during check error");
   chk_tx_stand:
      assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte)) else $error("tx byte dropped");
endmodule
bind acc_core acc_core_chk u_acc_core_chk (.*);
`default_nettype wire

//--- verif/acc_core_tb.sv
// Self-checking bench for the core.
// Assumes shortened cycle bases of 8000 ps and the converter model.
`timescale 1ns/1ps
`default_nettype none
module adc_channel_average_crc_core_test;
   import acc_pkg::*;
   localparam int CB = 8000 / 4000; // Base cycles
   logic        clk, nrst, oscillator_select, turbo_mode, comp_strobe, statistics_enable, bus_conv_start;
   logic        conversion_trigger_bit, autonomous_mode, done_clear, averaging_done_flag, scl_hold_low;
   logic        run_busy, sample_req, sample_valid, avg_valid, crc_en, rx_valid, rx_addr, error_clear;
   logic        inbound_check_error, wr_valid, tx_load, tx_accept, tx_valid, tx_ready, auto_on;
   logic [3:0]  clk_div, adc_delay;
   logic [7:0]  pin_kind, pin_dir, output_driver_type, output_level_word, event_drive_en, event_level;
   logic [7:0]  window_event, pad_in, pad_out, pad_oe, pin_level_word, sequence_channel_mask, ext_level;
   logic [7:0]  rx_data, wr_data, latest_result_low, latest_result_high, tx_data, tx_byte, d, pp, ov;
   logic [2:0]  averaging_ratio, start_channel, read_channel, sample_channel;
   logic [11:0] sample_data, cmp_value;
   logic [15:0] avg_result, rnd;
   logic [15:0] avg_q[$];
   logic [7:0]  wr_q[$];
   int          miscompares, n_compared, n;
   acc_core #(.COMP_BASE_PS_P(8000), .SMP_BASE_PS_P(8000)) u_acc_core (.*);
   acc_adc_model u_acc_adc_model (.*);
   // Own drive or outside level
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Zero preset: byte seeds register
   function automatic logic [7:0] crc8(input logic [7:0] b);
      logic [7:0] c;
      c = b;
      repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
      return c;
   endfunction
   task automatic report_and_stop();
      if (miscompares == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Bounded wait, cnt edges
   task automatic wait_for(ref logic s, input logic lvl, output int cnt);
      cnt = 0;
      do
      begin
         @(posedge clk);
         cnt++;
      end
      while (s !== lvl && cnt < 3000);
      if (s !== lvl)
      begin
         miscompares++;
         report_and_stop();
      end
   endtask
   // One link byte, data scrambled after
   task automatic send(input logic [7:0] b, input logic a);
      rx_valid <= 1'b1;
      rx_data  <= b;
      rx_addr  <= a;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data  <= ~b;
      @(posedge clk);
   endtask
   // ==========
   // Scoreboard
   // ==========
   always @(posedge clk)
   begin
      if (avg_valid === 1'b1 && auto_on)
         check("auto result", {sequence_channel_mask[avg_result[15:13]], avg_result[12:0]}, 14'h2A50);
      else if (avg_valid === 1'b1)
         check("avg result", avg_result, avg_q.size() ? avg_q.pop_front() : 16'hxxxx);
      if (wr_valid === 1'b1)
         check("write byte", wr_data, wr_q.size() ? wr_q.pop_front() : 8'hxx);
   end
   // ==========
   // Stimulus
   // ==========
   initial
   begin
      {nrst, oscillator_select, turbo_mode, clk_div, adc_delay, pin_kind, pin_dir, output_driver_type} = '0;
      {output_level_word, event_drive_en, event_level, window_event, ext_level, averaging_ratio} = '0;
      {start_channel, read_channel, statistics_enable, bus_conv_start, conversion_trigger_bit} = '0;
      {autonomous_mode, sequence_channel_mask, done_clear, crc_en, rx_valid, rx_addr, rx_data} = '0;
      {error_clear, tx_load, tx_data, tx_ready, auto_on} = '0;
      {miscompares, n_compared} = '0;
      rnd = 16'hB0B2;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      // Random pin setups
      repeat (6)
      begin
         @(posedge clk);
         rnd = lfsr(rnd);
         {pin_kind, pin_dir} <= rnd;
         rnd = lfsr(rnd);
         {output_driver_type, output_level_word} <= rnd;
         rnd = lfsr(rnd);
         {event_drive_en, event_level} <= rnd;
         rnd = lfsr(rnd);
         {window_event, ext_level} <= rnd;
         repeat (3) @(posedge clk);
         pp = pin_kind & pin_dir & output_driver_type;
         ov = (window_event & event_drive_en & event_level) | (~(window_event & event_drive_en) & output_level_word);
         check("push-pull enable", pad_oe & pp, pp);
         check("output level", pad_out & pp, ov & pp);
         check("pin level word", pin_level_word, pad_in);
      end
      // Bus-started runs
      for (int i = 0; i < 4; i++)
      begin
         averaging_ratio <= 3'(i * 2 + (i == 3));
         start_channel   <= 3'(i + 1);
         adc_delay       <= 4'(i * 3);
         avg_q.push_back({3'(i + 1), 9'h0A5, 4'h0});
         bus_conv_start  <= 1'b1;
         @(posedge clk);
         bus_conv_start  <= 1'b0;
         wait_for(avg_valid, 1'b1, n);
         check("run length", 16'(n >= (1 << (i * 2 + (i == 3))) * CB), 16'h0001);
      end
      // Trigger refused, then a polled run
      start_channel <= 3'h6;
      conversion_trigger_bit <= 1'b1;
      @(posedge clk);
      conversion_trigger_bit <= 1'b0;
      repeat (2) @(posedge clk);
      check("refused trigger", run_busy, 1'b0);
      statistics_enable <= 1'b1;
      conversion_trigger_bit <= 1'b1;
      avg_q.push_back(16'hCA50);
      @(posedge clk);
      conversion_trigger_bit <= 1'b0;
      wait_for(averaging_done_flag, 1'b1, n);
      read_channel <= 3'h6;
      done_clear <= 1'b1;
      @(posedge clk);
      done_clear <= 1'b0;
      repeat (2) @(posedge clk);
      check("latest result", {latest_result_high, latest_result_low}, 16'hCA50);
      check("done cleared", averaging_done_flag, 1'b0);
      // Autonomous runs, two channels
      auto_on <= 1'b1;
      sequence_channel_mask <= 8'h24;
      autonomous_mode <= 1'b1;
      repeat (4) wait_for(avg_valid, 1'b1, n);
      autonomous_mode <= 1'b0;
      wait_for(run_busy, 1'b0, n);
      @(posedge clk);
      auto_on <= 1'b0;
      // Turbo: fast div 0 and 1, slow div 0
      for (int i = 0; i < 3; i++)
      begin
         clk_div <= 4'(i == 1);
         oscillator_select <= (i == 2);
         turbo_mode <= 1'b1;
         repeat (3) wait_for(comp_strobe, 1'b1, n);
         check("turbo cycle", 16'(n), 16'(i == 0 ? CB : i == 1 ? CB * 3 / 2 : CB * 32));
      end
      turbo_mode <= 1'b0;
      // Checked writes, bad check, blocked write
      crc_en <= 1'b1;
      send(8'h2A, 1'b1);
      repeat (4)
      begin
         rnd = lfsr(rnd);
         d = rnd[7:0];
         wr_q.push_back(d);
         send(d, 1'b0);
         send(crc8(d), 1'b0);
      end
      send(8'h5C, 1'b0);
      send(crc8(8'h5C) ^ 8'h01, 1'b0);
      send(8'h33, 1'b0);
      send(crc8(8'h33), 1'b0);
      check("check error", inbound_check_error, 1'b1);
      error_clear <= 1'b1;
      @(posedge clk);
      error_clear <= 1'b0;
      wr_q.push_back(8'h77);
      send(8'h77, 1'b0);
      send(crc8(8'h77), 1'b0);
      crc_en <= 1'b0;
      wr_q.push_back(8'h99);
      send(8'h99, 1'b0);
      // Sent bytes with check bytes, link stalling
      crc_en <= 1'b1;
      repeat (3)
      begin
         rnd = lfsr(rnd);
         tx_data <= rnd[7:0];
         tx_load <= 1'b1;
         @(posedge clk);
         tx_load <= 1'b0;
         for (int k = 0; k < 2; k++)
         begin
            wait_for(tx_valid, 1'b1, n);
            check("sent byte", tx_byte, k ? crc8(rnd[7:0]) : rnd[7:0]);
            repeat (rnd[9:8] + k) @(posedge clk);
            tx_ready <= 1'b1;
            @(posedge clk);
            tx_ready <= 1'b0;
         end
      end
      repeat (3) @(posedge clk);
      check("left notes", 16'(avg_q.size() + wr_q.size()), 16'h0000);
      report_and_stop();
   end
endmodule
`default_nettype wire
